// file: hw/seep_host.sv
// bus master end: drives the serial clock and runs write and read commands
`timescale 1ns/1ps
module seep_host #(
  parameter int QTR = seep_pkg::HOST_QTR
) (
  input wire logic ref_clk,
  input wire logic rst,
  seep_if.host bus,
  input wire logic cmd_go,
  input wire logic cmd_read,
  input wire logic cmd_set_addr,
  input wire logic [2:0] cmd_chip_sel,
  input wire logic [12:0] cmd_addr,
  input wire logic [5:0] cmd_len,
  input wire logic [7:0] wr_data,
  output logic wr_take,
  output logic [7:0] rd_data,
  output logic rd_valid,
  output logic done,
  output logic nack_err,
  output logic busy
);
  localparam int QW = $clog2(QTR);
  localparam logic [QW-1:0] Q_LAST = QW'(QTR - 1);

  typedef enum logic [7:0] {
    H_IDLE = 8'b00000001,
    H_START = 8'b00000010,
    H_CTRL = 8'b00000100,
    H_AHI = 8'b00001000,
    H_ALO = 8'b00010000,
    H_WDAT = 8'b00100000,
    H_RDAT = 8'b01000000,
    H_STOP = 8'b10000000
  } seep_hstate_type;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  seep_hstate_type st_reg, st_next;
  logic [QW-1:0] tick_reg, tick_next;
  logic [1:0] q_reg, q_next;
  logic [3:0] bit_reg, bit_next;
  logic [7:0] tx_reg, tx_next, rx_reg, rx_next, rd_reg, rd_next;
  logic scl_reg, scl_next, oe_reg, oe_next, ack_reg, ack_next;
  logic rs_reg, rs_next, rd_rw_reg, rd_rw_next, sa_reg, sa_next;
  logic [2:0] cs_reg, cs_next;
  logic [12:0] addr_reg, addr_next;
  logic [5:0] left_reg, left_next, space;
  logic take_reg, take_next, rv_reg, rv_next, done_reg, done_next;
  logic err_reg, err_next, sda_s1_reg, sda_s2_reg, rw_cur;
  logic busy_reg, busy_next;

  assign bus.scl = scl_reg;
  assign bus.host_sda_out = 1'b0;
  assign bus.host_sda_oe = oe_reg;
  assign wr_take = take_reg;
  assign rd_data = rd_reg;
  assign rd_valid = rv_reg;
  assign done = done_reg;
  assign nack_err = err_reg;
  assign busy = busy_reg; // registered so the port comes from a flop
  // direction of the control byte: write first when an address is set
  assign rw_cur = rd_rw_reg && (rs_reg || !sa_reg);
  assign space = 6'h20 - {1'b0, cmd_addr[4:0]};

  // ---------------------------------------------------------------
  // command sequencer and bit engine
  // ---------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    tick_next = tick_reg;
    q_next = q_reg;
    bit_next = bit_reg;
    tx_next = tx_reg;
    rx_next = rx_reg;
    rd_next = rd_reg;
    scl_next = scl_reg;
    oe_next = oe_reg;
    ack_next = ack_reg;
    rs_next = rs_reg;
    rd_rw_next = rd_rw_reg;
    sa_next = sa_reg;
    cs_next = cs_reg;
    addr_next = addr_reg;
    left_next = left_reg;
    take_next = 1'b0;
    rv_next = 1'b0;
    done_next = 1'b0;
    err_next = err_reg;
    if (st_reg == H_IDLE) begin
      if (cmd_go) begin
        st_next = H_START;
        tick_next = Q_LAST;
        q_next = 2'h0;
        rs_next = 1'b0;
        rd_rw_next = cmd_read;
        sa_next = cmd_set_addr || !cmd_read;
        cs_next = cmd_chip_sel;
        addr_next = cmd_addr;
        err_next = 1'b0;
        left_next = (cmd_len == 6'h0) ? 6'h1 : cmd_len;
        if (!cmd_read && cmd_len > space) begin
          left_next = space;
        end
      end
    end else if (tick_reg != '0) begin
      tick_next = tick_reg - 1'b1;
    end else begin
      tick_next = Q_LAST;
      q_next = q_reg + 1'b1;
      if (st_reg == H_START) begin
        unique case (q_reg)
          2'h0: oe_next = 1'b0;
          2'h1: scl_next = 1'b1;
          2'h2: oe_next = 1'b1;
          default: begin
            scl_next = 1'b0;
            st_next = H_CTRL;
            bit_next = 4'h0;
            tx_next = {seep_pkg::TYPE_CODE, cs_reg, rw_cur};
          end
        endcase
      end else if (st_reg == H_STOP) begin
        unique case (q_reg)
          2'h0: oe_next = 1'b1;
          2'h1: scl_next = 1'b1;
          2'h2: oe_next = 1'b0;
          default: begin
            st_next = H_IDLE;
            done_next = 1'b1;
          end
        endcase
      end else begin
        unique case (q_reg)
          2'h0: begin
            if (bit_reg != seep_pkg::ACK_BIT) begin
              oe_next = (st_reg != H_RDAT) && !tx_reg[3'(7 - bit_reg)];
            end else begin
              oe_next = (st_reg == H_RDAT) && (left_reg != 6'h1);
            end
          end
          2'h1: scl_next = 1'b1;
          2'h2: begin
            if (bit_reg != seep_pkg::ACK_BIT) begin
              rx_next = {rx_reg[6:0], sda_s2_reg};
            end else begin
              ack_next = !sda_s2_reg;
            end
          end
          default: begin
            scl_next = 1'b0;
            bit_next = bit_reg + 1'b1;
            if (bit_reg == seep_pkg::ACK_BIT) begin
              bit_next = 4'h0;
              unique case (st_reg)
                H_CTRL: begin
                  if (!ack_reg) begin
                    st_next = H_START;
                  end else if (rw_cur) begin
                    st_next = H_RDAT;
                  end else begin
                    st_next = H_AHI;
                    tx_next = {3'h0, addr_reg[12:8]};
                  end
                end
                H_AHI: begin
                  st_next = ack_reg ? H_ALO : H_STOP;
                  err_next = !ack_reg;
                  tx_next = addr_reg[7:0];
                end
                H_ALO: begin
                  err_next = !ack_reg;
                  if (!ack_reg) begin
                    st_next = H_STOP;
                  end else if (rd_rw_reg) begin
                    st_next = H_START;
                    rs_next = 1'b1;
                  end else begin
                    st_next = H_WDAT;
                    tx_next = wr_data;
                    take_next = 1'b1;
                  end
                end
                H_WDAT: begin
                  left_next = left_reg - 1'b1;
                  err_next = !ack_reg;
                  if (left_reg == 6'h1 || !ack_reg) begin
                    st_next = H_STOP;
                  end else begin
                    tx_next = wr_data;
                    take_next = 1'b1;
                  end
                end
                default: begin
                  rd_next = rx_reg;
                  rv_next = 1'b1;
                  left_next = left_reg - 1'b1;
                  if (left_reg == 6'h1) begin
                    st_next = H_STOP;
                  end
                end
              endcase
            end
          end
        endcase
      end
    end
    busy_next = st_next != H_IDLE;
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_reg <= H_IDLE;
      tick_reg <= '0;
      q_reg <= 2'h0;
      bit_reg <= 4'h0;
      tx_reg <= 8'h00;
      rx_reg <= 8'h00;
      rd_reg <= 8'h00;
      scl_reg <= 1'b1;
      oe_reg <= 1'b0;
      ack_reg <= 1'b0;
      rs_reg <= 1'b0;
      rd_rw_reg <= 1'b0;
      sa_reg <= 1'b0;
      cs_reg <= 3'h0;
      addr_reg <= 13'h0000;
      left_reg <= 6'h00;
      take_reg <= 1'b0;
      rv_reg <= 1'b0;
      done_reg <= 1'b0;
      err_reg <= 1'b0;
      busy_reg <= 1'b0;
      sda_s1_reg <= 1'b1;
      sda_s2_reg <= 1'b1;
    end else begin
      st_reg <= st_next;
      tick_reg <= tick_next;
      q_reg <= q_next;
      bit_reg <= bit_next;
      tx_reg <= tx_next;
      rx_reg <= rx_next;
      rd_reg <= rd_next;
      scl_reg <= scl_next;
      oe_reg <= oe_next;
      ack_reg <= ack_next;
      rs_reg <= rs_next;
      rd_rw_reg <= rd_rw_next;
      sa_reg <= sa_next;
      cs_reg <= cs_next;
      addr_reg <= addr_next;
      left_reg <= left_next;
      take_reg <= take_next;
      rv_reg <= rv_next;
      done_reg <= done_next;
      err_reg <= err_next;
      busy_reg <= busy_next;
      sda_s1_reg <= bus.sda;
      sda_s2_reg <= sda_s1_reg;
    end
  end
endmodule : seep_host

// file: common/seep_pkg.sv
// shared constants for the serial eeprom command layer and its bus master
package seep_pkg;
  // ---------------------------------------------------------------
  // array and page geometry, device-type code and ack slot index
  // ---------------------------------------------------------------
  localparam int ADDR_W = 13;
  localparam int MEM_DEPTH = 8192;
  localparam int PAGE_W = 5;
  localparam int PAGE_SIZE = 32;
  localparam logic [1:0] PROT_TOP = 2'h3; // addr[12:11] of protected quarter
  localparam logic [3:0] TYPE_CODE = 4'h5; // device-type code, value arbitrary
  localparam logic [3:0] ACK_BIT = 4'h8; // bit index of the ack slot
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  localparam int PROG_TIME_NS = 5000000;
  localparam int PROG_CYCLES = PROG_TIME_NS / CLK_PERIOD_NS;
  localparam int HOST_QTR = 5; // ref_clk cycles per quarter bit on the host
endpackage : seep_pkg

// file: common/seep_if.sv
// two-wire link between the eeprom device end and the bus master end
`timescale 1ns/1ps
interface seep_if;
  logic scl;
  logic host_sda_out;
  logic host_sda_oe;
  logic dev_sda_out;
  logic dev_sda_oe;
  logic sda;
  // open-drain wire with pull-up
  assign sda = !((host_sda_oe && !host_sda_out) || (dev_sda_oe && !dev_sda_out));
  modport dev (input scl, input sda, output dev_sda_out, output dev_sda_oe);
  modport host (output scl, output host_sda_out, output host_sda_oe, input sda);
endinterface : seep_if

// file: hw/seep_device.sv
// eeprom slave: command layer, page buffer, write protect and array
`timescale 1ns/1ps
module seep_device #(
  parameter int PROG_CYCLES = seep_pkg::PROG_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst,
  seep_if.dev bus,
  input wire logic protect,
  input wire logic chip_sel_bit0,
  input wire logic chip_sel_bit1,
  input wire logic chip_sel_bit2,
  output logic busy
);
  localparam int TW = $clog2(PROG_CYCLES + 1);
  localparam logic [TW-1:0] TMR_LAST = TW'(PROG_CYCLES - 1);
  localparam int AW = seep_pkg::ADDR_W;
  localparam int PW = seep_pkg::PAGE_W;

  typedef enum logic [5:0] {
    D_IDLE = 6'b000001,
    D_CTRL = 6'b000010,
    D_AHI = 6'b000100,
    D_ALO = 6'b001000,
    D_WDAT = 6'b010000,
    D_RDAT = 6'b100000
  } seep_dstate_type;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [5:0] sync1_reg, sync2_reg;
  logic scl_old_reg, sda_old_reg;
  seep_dstate_type state_reg, state_next;
  logic [3:0] cnt_reg, cnt_next;
  logic [7:0] shift_reg, shift_next;
  logic [7:0] txd_reg, txd_next;
  logic oe_reg, oe_next;
  logic [AW-1:0] ptr_reg, ptr_next;
  logic [AW-9:0] hi_reg, hi_next;
  logic wrote_reg, wrote_next;
  logic [seep_pkg::PAGE_SIZE-1:0] valid_reg, valid_next;
  logic prog_reg, prog_next;
  logic [TW-1:0] tmr_reg, tmr_next;
  logic [PW:0] pidx_reg, pidx_next;
  logic [7:0] mem [0:seep_pkg::MEM_DEPTH-1];
  logic [7:0] page_buf [0:seep_pkg::PAGE_SIZE-1];
  logic mem_we, buf_we;
  logic [AW-1:0] mem_addr;

  // synchronised pins and their edges
  logic s_scl, s_sda, s_prot;
  logic [2:0] s_cs;
  logic scl_rise, scl_fall, start_ev, stop_ev, sel_ok;
  assign s_scl = sync2_reg[5];
  assign s_sda = sync2_reg[4];
  assign s_prot = sync2_reg[3];
  assign s_cs = sync2_reg[2:0];
  assign scl_rise = s_scl && !scl_old_reg;
  assign scl_fall = !s_scl && scl_old_reg;
  assign start_ev = s_scl && scl_old_reg && sda_old_reg && !s_sda;
  assign stop_ev = s_scl && scl_old_reg && !sda_old_reg && s_sda;
  // type code and chip select must both match, and no cycle running
  assign sel_ok = shift_reg[7:4] == seep_pkg::TYPE_CODE && shift_reg[3:1] == s_cs && !prog_reg;

  assign bus.dev_sda_out = 1'b0;
  assign bus.dev_sda_oe = oe_reg;
  assign busy = prog_reg;
  assign mem_addr = {ptr_reg[AW-1:PW], pidx_reg[PW-1:0]};

  // ---------------------------------------------------------------
  // protocol next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    shift_next = shift_reg;
    txd_next = txd_reg;
    oe_next = oe_reg;
    ptr_next = ptr_reg;
    hi_next = hi_reg;
    wrote_next = wrote_reg;
    valid_next = valid_reg;
    prog_next = prog_reg;
    tmr_next = tmr_reg;
    pidx_next = pidx_reg;
    mem_we = 1'b0;
    buf_we = 1'b0;
    // self-timed cycle: copy buffer into the page, then wait out the timer
    if (prog_reg) begin
      tmr_next = tmr_reg + 1'b1;
      if (!pidx_reg[PW]) begin
        mem_we = valid_reg[pidx_reg[PW-1:0]];
        pidx_next = pidx_reg + 1'b1;
      end
      if (tmr_reg == TMR_LAST) begin
        prog_next = 1'b0;
        valid_next = '0;
      end
    end
    if (start_ev) begin
      state_next = D_CTRL;
      cnt_next = 4'h0;
      oe_next = 1'b0;
      if (!prog_reg) begin
        wrote_next = 1'b0; // restart abandons any buffered write
        valid_next = '0;
      end
    end else if (stop_ev) begin
      state_next = D_IDLE;
      cnt_next = 4'h0;
      oe_next = 1'b0;
      wrote_next = 1'b0;
      if (state_reg == D_WDAT && wrote_reg) begin
        if (s_prot && ptr_reg[AW-1:AW-2] == seep_pkg::PROT_TOP) begin
          valid_next = '0;
        end else begin
          prog_next = 1'b1;
          tmr_next = '0;
          pidx_next = '0;
        end
      end
    end else if (scl_rise && state_reg != D_IDLE) begin
      if (cnt_reg != seep_pkg::ACK_BIT) begin
        shift_next = {shift_reg[6:0], s_sda};
        cnt_next = cnt_reg + 1'b1;
      end else begin
        cnt_next = 4'h0;
        if (state_reg == D_RDAT) begin
          if (s_sda) begin
            state_next = D_IDLE;
          end else begin
            txd_next = mem[ptr_reg];
          end
        end
      end
    end else if (scl_fall && state_reg != D_IDLE) begin
      if (cnt_reg == seep_pkg::ACK_BIT) begin
        unique case (state_reg)
          D_CTRL: begin
            if (sel_ok) begin
              oe_next = 1'b1;
              state_next = shift_reg[0] ? D_RDAT : D_AHI;
              txd_next = mem[ptr_reg];
            end else begin
              state_next = D_IDLE;
            end
          end
          D_AHI: begin
            hi_next = shift_reg[AW-9:0];
            oe_next = 1'b1;
            state_next = D_ALO;
          end
          D_ALO: begin
            ptr_next = {hi_reg, shift_reg};
            oe_next = 1'b1;
            state_next = D_WDAT;
            valid_next = '0;
          end
          D_WDAT: begin
            buf_we = 1'b1;
            valid_next[ptr_reg[PW-1:0]] = 1'b1;
            ptr_next[PW-1:0] = ptr_reg[PW-1:0] + 1'b1;
            wrote_next = 1'b1;
            oe_next = 1'b1;
          end
          D_RDAT: begin
            oe_next = 1'b0; // leave the ack slot to the master
            ptr_next = ptr_reg + 1'b1;
          end
          default: begin
            oe_next = 1'b0;
          end
        endcase
      end else if (state_reg == D_RDAT) begin
        oe_next = !txd_reg[3'(7 - cnt_reg)];
      end else begin
        oe_next = 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sync1_reg <= 6'h3f;
      sync2_reg <= 6'h3f;
      scl_old_reg <= 1'b1;
      sda_old_reg <= 1'b1;
      state_reg <= D_IDLE;
      cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      txd_reg <= 8'h00;
      oe_reg <= 1'b0;
      ptr_reg <= '0;
      hi_reg <= '0;
      wrote_reg <= 1'b0;
      valid_reg <= '0;
      prog_reg <= 1'b0;
      tmr_reg <= '0;
      pidx_reg <= '0;
    end else begin
      sync1_reg <= {bus.scl, bus.sda, protect, chip_sel_bit2, chip_sel_bit1, chip_sel_bit0};
      sync2_reg <= sync1_reg;
      scl_old_reg <= s_scl;
      sda_old_reg <= s_sda;
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      shift_reg <= shift_next;
      txd_reg <= txd_next;
      oe_reg <= oe_next;
      ptr_reg <= ptr_next;
      hi_reg <= hi_next;
      wrote_reg <= wrote_next;
      valid_reg <= valid_next;
      prog_reg <= prog_next;
      tmr_reg <= tmr_next;
      pidx_reg <= pidx_next;
    end
  end

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  // array and page buffer, written by index
  always_ff @(posedge ref_clk) begin
    if (mem_we) begin
      mem[mem_addr] <= page_buf[pidx_reg[PW-1:0]];
    end
    if (buf_we) begin
      page_buf[ptr_reg[PW-1:0]] <= shift_reg;
    end
  end
endmodule : seep_device

// file: verif/seep_link_checker.sv
// wire-level checks on the two-wire link between the host and device ends
`timescale 1ns/1ps
module seep_link_checker #(
  parameter int QTR = seep_pkg::HOST_QTR
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic scl,
  input wire logic host_sda_out,
  input wire logic host_sda_oe,
  input wire logic dev_sda_out,
  input wire logic dev_sda_oe,
  input wire logic sda
);
  localparam int LOW_MAX = 2 * QTR + 2;
  localparam int START_MAX = QTR + 2;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // ---------------------------------------------------------------
  // bus conditions
  // ---------------------------------------------------------------
  sequence start_seq;
    scl && $fell(sda);
  endsequence
  sequence stop_seq;
    scl && $rose(sda);
  endsequence
  sequence clock_pulse;
    ##[1:LOW_MAX] $rose(scl) ##1 scl [*7];
  endsequence
  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  chk_host_open_drain: assert property (host_sda_out == 1'b0)
    else $error("host drives sda high");
  chk_dev_open_drain: assert property (dev_sda_out == 1'b0)
    else $error("device drives sda high");
  chk_dev_edge_low: assert property ($changed(dev_sda_oe) |-> !scl)
    else $error("device changed sda while scl high");
  chk_dev_bit_held: assert property ($rose(dev_sda_oe) |-> dev_sda_oe throughout clock_pulse)
    else $error("device released sda before clock pulse ended");
  chk_one_driver: assert property (scl |-> !(dev_sda_oe && host_sda_oe))
    else $error("both ends drive sda while scl high");
  chk_scl_high_min: assert property ($rose(scl) |-> scl [*8])
    else $error("scl high phase too short");
  chk_scl_low_min: assert property ($fell(scl) |-> !scl [*8])
    else $error("scl low phase too short");
  chk_scl_low_max: assert property ($fell(scl) |-> ##[1:LOW_MAX] $rose(scl))
    else $error("scl low phase too long");
  chk_start_then_clock: assert property (start_seq |-> ##[1:START_MAX] $fell(scl))
    else $error("no clock after start");
  chk_stop_idle: assert property (stop_seq |-> (scl && sda) [*8])
    else $error("bus not idle after stop");
  // main scenarios
  cov_start: cover property (start_seq);
  cov_stop: cover property (stop_seq);
endmodule : seep_link_checker

// file: verif/tb_top.sv
// self-checking bench: host end and device end joined over the link
`timescale 1ns/1ps
module tb_top;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic protect = 1'b0;
  logic cmd_go = 1'b0;
  logic cmd_read = 1'b0;
  logic cmd_set_addr = 1'b0;
  logic [12:0] cmd_addr = 13'h0000;
  logic [5:0] cmd_len = 6'h01;
  logic [7:0] wr_data = 8'h00;
  logic wr_take, rd_valid, done, nack_err, host_busy, dev_busy;
  logic [7:0] rd_data;
  logic [7:0] rdq [$];
  int n_fail = 0;
  int n_compared = 0;
  int i;
  int n_start = 0;
  logic sda_old = 1'b1;
  logic [2:0] cs_pins = 3'h6; // chip select pins, bit 0 unlike bits 1 and 2 so swapping it with either hangs the host
  // ---------------------------------------------------------------
  // clock, link, ends and checker
  // ---------------------------------------------------------------
  always #12.5 ref_clk = ~ref_clk;
  seep_if link ();
  // programming long enough that the first poll after a write is refused
  seep_device #(.PROG_CYCLES(300)) seep_device_inst (.ref_clk(ref_clk), .rst(rst), .bus(link), .protect(protect),
    .chip_sel_bit0(cs_pins[0]), .chip_sel_bit1(cs_pins[1]), .chip_sel_bit2(cs_pins[2]), .busy(dev_busy));
  seep_host #(.QTR(5)) seep_host_inst (.ref_clk(ref_clk), .rst(rst), .bus(link), .cmd_go(cmd_go),
    .cmd_read(cmd_read), .cmd_set_addr(cmd_set_addr), .cmd_chip_sel(cs_pins), .cmd_addr(cmd_addr),
    .cmd_len(cmd_len), .wr_data(wr_data), .wr_take(wr_take), .rd_data(rd_data), .rd_valid(rd_valid),
    .done(done), .nack_err(nack_err), .busy(host_busy));
  seep_link_checker #(.QTR(5)) seep_link_checker_inst (.ref_clk(ref_clk), .rst(rst), .scl(link.scl),
    .host_sda_out(link.host_sda_out), .host_sda_oe(link.host_sda_oe), .dev_sda_out(link.dev_sda_out),
    .dev_sda_oe(link.dev_sda_oe), .sda(link.sda));
  // count start conditions on the link, sampled where the wires are settled
  always @(negedge ref_clk) begin
    if (link.scl && sda_old && !link.sda) n_start++;
    sda_old <= link.sda;
  end
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic close_out();
    if (n_fail == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : close_out
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // byte at offset k of a write that began with seed; step 11h per byte
  function automatic logic [7:0] pat(input logic [7:0] seed, input int k);
    return seed + 8'(k * 17);
  endfunction : pat
  // one host command; bytes read are queued in rdq
  task automatic run_cmd(input logic rd, input logic set_a, input logic [12:0] addr, input logic [5:0] len,
                         input logic [7:0] seed);
    int k;
    int n;
    n = 0;
    rdq.delete();
    @(negedge ref_clk);
    cmd_read = rd;
    cmd_set_addr = set_a;
    cmd_addr = addr;
    cmd_len = len;
    wr_data = seed;
    cmd_go = 1'b1;
    @(negedge ref_clk);
    cmd_go = 1'b0;
    check({7'h00, host_busy}, 8'h01);
    for (k = 0; k < 40000; k++) begin
      if (wr_take === 1'b1) begin
        n++;
        wr_data = pat(seed, n);
      end
      if (rd_valid === 1'b1) rdq.push_back(rd_data);
      if (done === 1'b1) break;
      @(negedge ref_clk);
    end
    if (k >= 40000) begin
      n_fail++;
      close_out();
    end else begin
      check({7'h00, nack_err}, 8'h00);
    end
  endtask : run_cmd
  // read len bytes (random read if set_a) and compare with the expected list
  task automatic read_chk(input logic set_a, input logic [12:0] addr, input logic [7:0] exp [$]);
    run_cmd(1'b1, set_a, addr, 6'(exp.size()), 8'h00);
    check(8'(rdq.size()), 8'(exp.size()));
    foreach (exp[j]) check(rdq[j], exp[j]);
  endtask : read_chk
  // device busy compared with exp a few cycles after a write's stop
  task automatic busy_chk(input logic exp);
    repeat (4) @(negedge ref_clk);
    check({7'h00, dev_busy}, {7'h00, exp});
  endtask : busy_chk
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    logic [7:0] pg [$];
    int s0;
    repeat (20) @(negedge ref_clk);
    rst = 1'b0;
    repeat (4) @(negedge ref_clk);
    // full page write at 0040h, then polling by the next command and read back
    run_cmd(1'b0, 1'b0, 13'h0040, 6'd32, 8'h10);
    busy_chk(1'b1);
    for (i = 0; i < 32; i++) pg.push_back(pat(8'h10, i));
    s0 = n_start;
    read_chk(1'b1, 13'h0040, pg);
    check(8'(n_start - s0 > 2), 8'h01);
    // byte write leaves the pointer one above
    run_cmd(1'b0, 1'b0, 13'h0042, 6'd1, 8'ha5);
    read_chk(1'b0, 13'h0000, '{pat(8'h10, 3)});
    read_chk(1'b1, 13'h0042, '{8'ha5});
    // random read then current-address read
    read_chk(1'b1, 13'h0050, '{pat(8'h10, 16)});
    read_chk(1'b0, 13'h0000, '{pat(8'h10, 17)});
    // write running off the page end is cut at the boundary; pointer wraps in the page
    run_cmd(1'b0, 1'b0, 13'h005e, 6'd4, 8'h70);
    read_chk(1'b0, 13'h0000, '{pat(8'h10, 0)});
    read_chk(1'b1, 13'h005e, '{8'h70, pat(8'h70, 1)});
    // sequential read across the top address
    run_cmd(1'b0, 1'b0, 13'h1fff, 6'd1, 8'h9c);
    run_cmd(1'b0, 1'b0, 13'h0000, 6'd1, 8'h3e);
    read_chk(1'b1, 13'h1fff, '{8'h9c, 8'h3e});
    // protected quarter refuses writes without a cycle
    run_cmd(1'b0, 1'b0, 13'h1800, 6'd1, 8'h21);
    protect = 1'b1;
    run_cmd(1'b0, 1'b0, 13'h1800, 6'd1, 8'hde);
    busy_chk(1'b0);
    read_chk(1'b1, 13'h1800, '{8'h21});
    // protect raised after the stop leaves the started write alone
    protect = 1'b0;
    run_cmd(1'b0, 1'b0, 13'h1801, 6'd1, 8'h66);
    protect = 1'b1;
    busy_chk(1'b1);
    read_chk(1'b1, 13'h1801, '{8'h66});
    protect = 1'b0;
    close_out();
  end
endmodule : tb_top
